// file: logic/gtu_pkg.sv
// Package: register map, field layout and carriers of the timer unit
package gtu_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] GTU_CTRL_OFS = 8'h00;
  localparam logic [7:0] GTU_CHMODE_OFS = 8'h04;
  localparam logic [7:0] GTU_EDGE_OFS = 8'h08;
  localparam logic [7:0] GTU_STATUS_OFS = 8'h0C;
  localparam logic [7:0] GTU_COUNT_OFS = 8'h10;
  localparam logic [7:0] GTU_ACC_OFS = 8'h14;
  localparam logic [7:0] GTU_PINS_OFS = 8'h18;
  localparam logic [7:0] GTU_CH0_OFS = 8'h20;

  // ---------------------------------------------------------------
  // Field positions and sizes
  // ---------------------------------------------------------------
  localparam int GTU_NCH = 4;
  localparam int GTU_CW = 16;
  localparam int GTU_PRE_STAGES = 7;
  localparam int GTU_ACC_CH = 3;
  localparam int GTU_CTRL_EN_BIT = 0;
  localparam int GTU_CTRL_PRE_LSB = 1;
  localparam int GTU_CTRL_ACC_EN_BIT = 4;
  localparam int GTU_CTRL_ACC_GATED_BIT = 5;
  localparam int GTU_CTRL_ACC_POL_BIT = 6;
  localparam int GTU_ST_OVF_BIT = 4;
  localparam int GTU_ST_ACC_BIT = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] GTU_CNT_RST = 16'h0000;
  localparam logic [2:0] GTU_PRE_RST = 3'h0;

  // Edge selection per capture channel
  typedef enum logic [1:0] {
    GTU_EDGE_OFF = 2'b00,
    GTU_EDGE_RISE = 2'b01,
    GTU_EDGE_FALL = 2'b10,
    GTU_EDGE_BOTH = 2'b11
  } gtu_edge_e;

  // Pin side of the unit
  typedef struct packed {
    logic [GTU_NCH-1:0] in;
  } gtu_pins_in_s;

endpackage

// file: logic/gtu_prescaler.sv
// Seven-stage binary prescaler issuing one tick per selected period
`timescale 1ns/1ps
module gtu_prescaler
  import gtu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [2:0] select,
  output logic tick
);

  typedef struct packed {
    logic [GTU_PRE_STAGES-1:0] div;
    logic tick;
  } gtu_pre_s;

  gtu_pre_s state_reg;
  gtu_pre_s state_next;
  logic [GTU_PRE_STAGES:0] wide;
  logic [GTU_PRE_STAGES-1:0] mask;

  // ---------------------------------------------------------------
  // Divider: select 0 passes every clock, 7 divides by 128
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wide = ({1'b0, {GTU_PRE_STAGES{1'b1}}}) << select;
    mask = ~wide[GTU_PRE_STAGES-1:0];
    state_next.tick = 1'b0;
    if (enable) begin
      state_next.div = state_reg.div + 7'h01;
      if ((state_reg.div & mask) == mask) begin
        state_next.tick = 1'b1;
      end
    end else begin
      state_next.div = 7'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule // gtu_prescaler

// file: logic/gtu_timer.sv
// Four-channel capture/compare timer with pulse accumulator, APB slave
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// - One 16-bit counter advances on ticks of a seven-stage prescaler.
// - Four channels, each set to capture or compare by its mode bit.
// - Channel three alone may instead run the pulse accumulator.
// - Counter wrap sets a sticky overflow flag for software.
// - Capture channel stores the counter on its selected pin edge.
// - Compare channel flags a match and toggles its output pin.
// - All channels not given to the accumulator work together against the one shared counter.
// - Accumulator is 16 bits, counting events or gated time.
module gtu_timer
  import gtu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gtu_pins_in_s pins_in,
  output logic [GTU_NCH-1:0] pin_out,
  output logic [GTU_NCH-1:0] pin_oe_n,
  output logic irq_pending
);

  typedef struct packed {
    logic [6:0] ctrl;
    logic [GTU_NCH-1:0] chmode;
    logic [2*GTU_NCH-1:0] edge_sel;
    logic [5:0] status;
    logic [GTU_CW-1:0] count;
    logic [GTU_CW-1:0] acc;
    logic [GTU_NCH*GTU_CW-1:0] chval;
    logic [GTU_NCH-1:0] in_d;
    logic [GTU_NCH-1:0] out;
    logic [GTU_NCH-1:0] oe_n;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
  } gtu_state_s;

  gtu_state_s state_reg;
  gtu_state_s state_next;
  logic tick;
  logic acc_mode;
  logic gate_act;
  logic [GTU_NCH-1:0] cap_ev;
  logic [GTU_NCH-1:0] cmp_ev;
  logic [GTU_NCH-1:0] rise;
  logic [GTU_NCH-1:0] fall;
  logic [5:0] set_ev;
  logic acc_ev;
  logic ovf_ev;
  logic wr_en;
  logic rd_en;
  logic hit;

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  gtu_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .enable(state_reg.ctrl[GTU_CTRL_EN_BIT]),
    .select(state_reg.ctrl[GTU_CTRL_PRE_LSB+:3]),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // Per-channel events
  // ---------------------------------------------------------------
  assign acc_mode = state_reg.ctrl[GTU_CTRL_ACC_EN_BIT];
  assign rise = pins_in.in & ~state_reg.in_d;
  assign fall = ~pins_in.in & state_reg.in_d;

  genvar gi;
  generate
    for (gi = 0; gi < GTU_NCH; gi++) begin : g_ch
      logic own;
      logic [1:0] es;
      // Channel three loses capture and compare to the accumulator; its pin drive still follows chmode
      assign own = (gi == GTU_ACC_CH) ? !acc_mode : 1'b1;
      assign es = state_reg.edge_sel[2*gi+:2];
      assign cap_ev[gi] = own && !state_reg.chmode[gi] &&
        ((rise[gi] && es[0]) || (fall[gi] && es[1]));
      assign cmp_ev[gi] = own && state_reg.chmode[gi] && tick &&
        state_reg.count == state_reg.chval[gi*GTU_CW+:GTU_CW];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pulse accumulator on channel three
  // ---------------------------------------------------------------
  // Polarity bit selects an active-low gate or falling edges
  assign gate_act = pins_in.in[GTU_ACC_CH] ^
    state_reg.ctrl[GTU_CTRL_ACC_POL_BIT];
  always_comb begin
    acc_ev = 1'b0;
    if (acc_mode) begin
      if (state_reg.ctrl[GTU_CTRL_ACC_GATED_BIT]) begin
        acc_ev = tick && gate_act;
      end else if (state_reg.ctrl[GTU_CTRL_ACC_POL_BIT]) begin
        acc_ev = fall[GTU_ACC_CH];
      end else begin
        acc_ev = rise[GTU_ACC_CH];
      end
    end
  end
  assign ovf_ev = tick && state_reg.count == 16'hFFFF;
  assign set_ev = {acc_ev, ovf_ev, cap_ev | cmp_ev};

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // A write lands on the access edge, the one where pready is high
  assign wr_en = psel && penable && pwrite && state_reg.ready;
  assign rd_en = psel && !penable && !pwrite;
  always_comb begin
    unique case (paddr)
      GTU_CTRL_OFS, GTU_CHMODE_OFS, GTU_EDGE_OFS, GTU_STATUS_OFS,
      GTU_COUNT_OFS, GTU_ACC_OFS, GTU_PINS_OFS: hit = 1'b1;
      GTU_CH0_OFS, GTU_CH0_OFS + 8'h04, GTU_CH0_OFS + 8'h08,
      GTU_CH0_OFS + 8'h0C: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    // Edge history resets low like the idle pins: no false edge
    state_next.in_d = pins_in.in;
    state_next.ready = psel && !penable;
    state_next.err = psel && !penable && !hit;
    if (tick) begin
      state_next.count = state_reg.count + 16'h0001;
    end
    if (acc_ev) begin
      state_next.acc = state_reg.acc + 16'h0001;
    end
    for (int i = 0; i < GTU_NCH; i++) begin
      if (cap_ev[i]) begin
        state_next.chval[i*GTU_CW+:GTU_CW] = state_reg.count;
      end
      if (cmp_ev[i]) begin
        state_next.out[i] = !state_reg.out[i];
      end
    end
    // -------------------------------------------------------------
    // Register write
    // -------------------------------------------------------------
    if (wr_en && hit) begin
      case (paddr)
        GTU_CTRL_OFS: state_next.ctrl = pwdata[6:0];
        GTU_CHMODE_OFS: state_next.chmode = pwdata[3:0];
        GTU_EDGE_OFS: state_next.edge_sel = pwdata[7:0];
        GTU_STATUS_OFS: state_next.status = state_reg.status & ~pwdata[5:0];
        GTU_COUNT_OFS: state_next.count = pwdata[15:0];
        GTU_ACC_OFS: state_next.acc = pwdata[15:0];
        GTU_PINS_OFS: state_next.out = pwdata[3:0];
        default: state_next.chval[paddr[3:2]*GTU_CW+:GTU_CW] = pwdata[15:0];
      endcase
    end
    // Drive enables follow the mode written at this same edge
    state_next.oe_n = ~state_next.chmode;
    // -------------------------------------------------------------
    // Status flags
    // -------------------------------------------------------------
    // Hardware set wins over a same-cycle software clear
    state_next.status = state_next.status | set_ev;
    state_next.irq = |state_next.status;
    // -------------------------------------------------------------
    // Register read
    // -------------------------------------------------------------
    // Taken in the setup cycle so the word stands beside pready
    if (rd_en) begin
      state_next.rdata = 32'h0000_0000;
      case (paddr)
        GTU_CTRL_OFS: state_next.rdata[6:0] = state_reg.ctrl;
        GTU_CHMODE_OFS: state_next.rdata[3:0] = state_reg.chmode;
        GTU_EDGE_OFS: state_next.rdata[7:0] = state_reg.edge_sel;
        GTU_STATUS_OFS: state_next.rdata[5:0] = state_reg.status;
        GTU_COUNT_OFS: state_next.rdata[15:0] = state_reg.count;
        GTU_ACC_OFS: state_next.rdata[15:0] = state_reg.acc;
        GTU_PINS_OFS: state_next.rdata[7:0] = {pins_in.in, state_reg.out};
        default: begin
          if (hit) begin
            state_next.rdata[15:0] =
              state_reg.chval[paddr[3:2]*GTU_CW+:GTU_CW];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      // Every channel starts in capture, its pin released
      state_reg.oe_n <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all registered
  // ---------------------------------------------------------------
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign pin_out = state_reg.out;
  // Compare channels drive their pin; capture channels release it
  assign pin_oe_n = state_reg.oe_n;
  assign irq_pending = state_reg.irq;

endmodule // gtu_timer

// file: verif/gtu_timer_assertions.sv
// Concurrent checks on the timer unit ports
`timescale 1ns/1ps
module gtu_timer_assertions
  import gtu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [GTU_NCH-1:0] pin_oe_n,
  input wire logic irq_pending
);
  // ------------------------------------------------------------
  // Bus and flag relations
  // ------------------------------------------------------------
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire wr_chm = wr && paddr == GTU_CHMODE_OFS;
  wire wr_st = wr && paddr == GTU_STATUS_OFS;
  sequence setup_s;
    psel && !penable;
  endsequence
  setup_answer_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready && psel)
    else $error("error without ready");
  hole_err_a: assert property ((setup_s and (paddr == 8'hFC)) |=> pslverr)
    else $error("unmapped not refused");
  ctrl_ok_a: assert property ((setup_s and (paddr == 8'h00)) |=> !pslverr)
    else $error("mapped refused");
  ctrl_rsvd_a: assert property (pready && !pwrite && paddr == 8'h00
    |-> prdata[31:7] == 25'h0) else $error("reserved bits set");
  // Drive enables only move after a mode write
  oe_cause_a: assert property (!$stable(pin_oe_n)
    |-> $past(wr_chm) || $past(wr_chm, 2)) else $error("oe moved");
  irq_hold_a: assert property ($fell(irq_pending)
    |-> $past(wr_st) || $past(wr_st, 2)) else $error("flag lost");
endmodule // gtu_timer_assertions
bind gtu_timer gtu_timer_assertions u_chk (.*);

// file: verif/gtu_pin_model.sv
// Waveform source on the timer input pins
`timescale 1ns/1ps
module gtu_pin_model
  import gtu_pkg::*;
(
  input wire logic pclk,
  output gtu_pins_in_s pins
);
  initial pins = '0;
  // Lows one clock longer than highs between pulses; each edge is caught at the next clock by the one-flop edge detector
  task automatic pulse(input int ch, input int n, input int w);
    repeat (n) begin
      @(posedge pclk);
      pins.in[ch] <= 1'b1;
      repeat (w) @(posedge pclk);
      pins.in[ch] <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask
endmodule // gtu_pin_model

// file: verif/testbench.sv
// Self-checking bench of the timer unit
`timescale 1ns/1ps
module testbench
  import gtu_pkg::*;
;
  // ------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, v;
  logic pready, pslverr, e, irq_pending;
  logic [3:0] pin_out, pin_oe_n;
  gtu_pins_in_s pins;
  int err_total = 0, check_count = 0;
  always #2.5 pclk = ~pclk;
  gtu_pin_model u_gtu_pin_model (.pclk(pclk), .pins(pins));
  gtu_timer u_gtu_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq_pending(irq_pending));
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input string n, input logic [31:0] x,
    input logic [31:0] y);
    check_count++;
    if (x !== y) begin
      $display("wrong value %s exp %h got %h", n, x, y);
      err_total++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x & m, q & m);
  endtask
  task automatic rng(input logic [7:0] a, input int lo, input int hi);
    apb(1'b0, a, 32'h0);
    check_count++;
    if ((q >= lo && q <= hi) !== 1'b1) begin
      $display("wrong value reg %h exp %0d..%0d got %h", a, lo, hi, q);
      err_total++;
    end
  endtask
  task automatic t_reset();
    chk("pin_oe_n", 32'hF, {28'h0, pin_oe_n});
    rd(GTU_COUNT_OFS, 32'h0, 32'hFFFF);
    apb(1'b0, 8'hFC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
  endtask
  task automatic t_capcmp();
    wr(GTU_CHMODE_OFS, 32'h2);
    @(posedge pclk);
    chk("pin_oe_n", 32'hD, {28'h0, pin_oe_n});
    wr(GTU_EDGE_OFS, 32'h1);
    wr(GTU_CH0_OFS + 8'h04, 32'h40);
    wr(GTU_CTRL_OFS, 32'h1);
    u_gtu_pin_model.pulse(0, 1, 4);
    repeat (80) @(posedge pclk);
    wr(GTU_CTRL_OFS, 32'h0);
    rd(GTU_STATUS_OFS, 32'h3, 32'h3);
    chk("pin_out1", 32'h1, {31'h0, pin_out[1]});
    chk("irq_pending", 32'h1, {31'h0, irq_pending});
    rng(GTU_CH0_OFS, 0, 2);
    wr(GTU_STATUS_OFS, 32'h3F);
    rd(GTU_STATUS_OFS, 32'h0, 32'h3F);
  endtask
  task automatic t_count();
    wr(GTU_COUNT_OFS, 32'h0);
    wr(GTU_CTRL_OFS, 32'h7);
    repeat (80) @(posedge pclk);
    wr(GTU_CTRL_OFS, 32'h0);
    rng(GTU_COUNT_OFS, 9, 12);
    wr(GTU_COUNT_OFS, 32'hFFF0);
    wr(GTU_CTRL_OFS, 32'h1);
    repeat (40) @(posedge pclk);
    wr(GTU_CTRL_OFS, 32'h0);
    rd(GTU_STATUS_OFS, 32'h10, 32'h10);
    wr(GTU_STATUS_OFS, 32'h3F);
  endtask
  task automatic t_acc();
    wr(GTU_ACC_OFS, 32'h0);
    wr(GTU_CTRL_OFS, 32'h11);
    u_gtu_pin_model.pulse(3, 5, 3);
    rd(GTU_ACC_OFS, 32'h5, 32'hFFFF);
    rd(GTU_STATUS_OFS, 32'h20, 32'h20);
    wr(GTU_ACC_OFS, 32'h0);
    wr(GTU_CTRL_OFS, 32'h31);
    u_gtu_pin_model.pulse(3, 1, 20);
    rng(GTU_ACC_OFS, 17, 23);
    v = q;
    repeat (10) @(posedge pclk);
    rd(GTU_ACC_OFS, v, 32'hFFFF);
    wr(GTU_ACC_OFS, 32'h0);
    wr(GTU_CTRL_OFS, 32'h51);
    u_gtu_pin_model.pulse(3, 2, 3);
    rd(GTU_ACC_OFS, 32'h2, 32'hFFFF);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_capcmp();
    t_count();
    t_acc();
    complete_run();
  end
endmodule // testbench
